// *** rtl/almsc_pkg.sv ***
// Purpose: shared constants of the angle loop mode-switch correction block
// Assumes: 32-bit APB register bus, one clock
// Notes:   every offset, field position and count lives here, and the mode, interrupt and position reset values
package almsc_pkg;
	// ==========================================================
	// widths
	localparam int POS_W  = 24;
	localparam int ADDR_W = 8;
	localparam int GAP_W  = 3;

	// ==========================================================
	// register byte offsets
	localparam logic [ADDR_W-1:0] OFF_MODE   = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_ENABLE = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_SVAL   = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_TVAL   = 8'h0C;
	localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_ISTAT  = 8'h14;
	localparam logic [ADDR_W-1:0] OFF_IMASK  = 8'h18;

	// ==========================================================
	// mode register fields
	localparam int MODE_EMERG_BIT = 0;
	localparam int MODE_SEN_BIT   = 1;
	localparam int MODE_TEN_BIT   = 2;
	localparam int MODE_W         = 3;
	localparam logic [MODE_W-1:0] MODE_RST = 3'h0;

	// enable register field
	localparam int ENABLE_BIT = 0;

	// status register fields
	localparam int STAT_LOCK_BIT   = 0;
	localparam int STAT_PEND_S_BIT = 1;
	localparam int STAT_PEND_T_BIT = 2;
	localparam int STAT_NOCORR_BIT = 3;

	// interrupt status and mask fields
	localparam int IRQ_SVAL_BIT   = 0;
	localparam int IRQ_TVAL_BIT   = 1;
	localparam int IRQ_LOST_BIT   = 2;
	localparam int IRQ_REGAIN_BIT = 3;
	localparam int IRQ_W          = 4;
	localparam logic [IRQ_W-1:0] IRQ_RST = 4'h0;

	// ==========================================================
	// position value reset and lock behaviour
	localparam logic [POS_W-1:0] POS_RST = 24'h000000;
	// gaps needed to regain lock after a direction change
	localparam logic [GAP_W-1:0] LOCK_GAPS = 3'h2;
endpackage : almsc_pkg

// *** rtl/almsc_lock_if.sv ***
// Purpose: carrier between the register core and the lock flag unit
// Assumes: all signals on the module clock
// Notes:   events are one-cycle pulses, the rest are levels
`timescale 1ns/1ps
interface almsc_lock_if;
	logic enable;
	logic emergency;
	logic dir_change;
	logic gap;
	logic state_slope;
	logic lock;

	modport ctrl (
		output enable,
		output emergency,
		output dir_change,
		output gap,
		output state_slope,
		input  lock
	);
	modport lock_unit (
		input  enable,
		input  emergency,
		input  dir_change,
		input  gap,
		input  state_slope,
		output lock
	);
endinterface : almsc_lock_if

// *** rtl/almsc_sync.sv ***
// Purpose: two-flop synchroniser for the sensor pins
// Assumes: inputs are asynchronous to clock
// Notes:   only the second stage may be read outside this module
`timescale 1ns/1ps
module almsc_sync #(
	parameter int W = 3
) (
	input  wire logic         clock,
	input  wire logic         rst_n,
	input  wire logic         ce,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} almsc_sync_t;

	almsc_sync_t q;
	almsc_sync_t d;

	// ==========================================================
	// per-bit stages
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			always_comb begin
				d.s1[i] = din[i];
				d.s2[i] = q.s1[i];
			end
		end
	endgenerate

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			q <= '0;
		end else if (ce) begin
			q <= d;
		end
	end

	assign dout = q.s2;
endmodule : almsc_sync

// *** rtl/almsc_lock.sv ***
// Purpose: primary phase locked flag of the angle tracking loop
// Assumes: event inputs are one-cycle pulses on clock
// Notes:   lock is regained after LOCK_GAPS consecutive missing-state events
`timescale 1ns/1ps
module almsc_lock (
	input  wire logic  clock,
	input  wire logic  rst_n,
	input  wire logic  ce,
	almsc_lock_if.lock_unit lk
);
	typedef struct packed {
		logic                       lock;
		logic [almsc_pkg::GAP_W-1:0] gaps;
	} almsc_lock_t;

	almsc_lock_t q;
	almsc_lock_t d;
	logic [almsc_pkg::GAP_W-1:0] gaps_inc;

	// ==========================================================
	// next state
	always_comb begin
		d        = q;
		gaps_inc = q.gaps + 3'h1;
		if (!lk.enable) begin
			d.lock = 1'b0;
			d.gaps = '0;
		end else if (lk.emergency && lk.dir_change) begin
			d.lock = 1'b0;
			d.gaps = '0;
		end else if (!q.lock) begin
			if (lk.gap) begin
				if (gaps_inc == almsc_pkg::LOCK_GAPS) begin
					d.lock = 1'b1;
					d.gaps = '0;
				end else begin
					d.gaps = gaps_inc;
				end
			end else if (lk.state_slope) begin
				// a seen state breaks the run of gaps
				d.gaps = '0;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			q <= '0;
		end else if (ce) begin
			q <= d;
		end
	end

	assign lk.lock = q.lock;
endmodule : almsc_lock

// *** rtl/almsc_top.sv ***
// Purpose: mode-switch position correction and lock flag of an angle loop
// Assumes: APB3 slave, single clock, measured values from the loop core
// Notes:   sensor pins are synchronised, core inputs are same-clock
//
// What this block does
// - emergency select 0 to 1: next STATE slope sets state value to measured +/- correction.
// - emergency select 1 to 0: next TRIGGER slope sets trigger value likewise.
// - after restart from disabled, the side value copies the measured value directly.
// - in emergency mode a direction change clears the primary lock flag.
// - lock flag set again after two consecutive missing-state gaps.
//
// Added by the designer: the APB slave port and the register offsets.
`timescale 1ns/1ps
module almsc_top (
	input  wire logic                       clock,
	input  wire logic                       rst_n,
	input  wire logic                       ce,
	// apb slave
	input  wire logic [almsc_pkg::ADDR_W-1:0] paddr,
	input  wire logic                       psel,
	input  wire logic                       penable,
	input  wire logic                       pwrite,
	input  wire logic [31:0]                pwdata,
	output logic      [31:0]                prdata,
	output logic                            pready,
	output logic                            pslverr,
	output logic                            irq,
	// sensor pins
	input  wire logic                       trigger_pin,
	input  wire logic                       state_pin,
	// loop core, same clock
	input  wire logic                       direction_fwd,
	input  wire logic                       missing_state_event,
	input  wire logic [almsc_pkg::POS_W-1:0] state_side_position_measured,
	input  wire logic [almsc_pkg::POS_W-1:0] trigger_side_position_measured,
	input  wire logic [almsc_pkg::POS_W-1:0] increment_counter_primary,
	input  wire logic [almsc_pkg::POS_W-1:0] state_pulse_count,
	input  wire logic [almsc_pkg::POS_W-1:0] trigger_pulse_count,
	// status towards the core
	output logic [almsc_pkg::POS_W-1:0]     state_side_position_value,
	output logic [almsc_pkg::POS_W-1:0]     trigger_side_position_value,
	output logic                            emergency_mode_select,
	output logic                            loop_enable_bit,
	output logic                            primary_phase_locked_flag
);
	typedef struct packed {
		logic [almsc_pkg::MODE_W-1:0] mode;
		logic                         en;
		logic                         pend_s;
		logic                         pend_t;
		logic                         nocorr;
		logic [almsc_pkg::POS_W-1:0]  sval;
		logic [almsc_pkg::POS_W-1:0]  tval;
		logic [almsc_pkg::IRQ_W-1:0]  ist;
		logic [almsc_pkg::IRQ_W-1:0]  imask;
		logic                         trg_d;
		logic                         sta_d;
		logic                         dir_d;
		logic                         lock_d;
		logic                         pready;
		logic                         pslverr;
		logic [31:0]                  prdata;
		logic                         irq;
	} almsc_top_t;

	almsc_top_t q;
	almsc_top_t d;

	logic [1:0]                  pins_s;
	logic                        trg_s;
	logic                        sta_s;
	logic                        trg_slope;
	logic                        sta_slope;
	logic                        lock_now;
	logic                        acc;
	logic                        wr;
	logic                        hit;
	logic                        new_emerg;
	logic [almsc_pkg::POS_W-1:0] corr_s;
	logic [almsc_pkg::POS_W-1:0] corr_t;
	logic [almsc_pkg::POS_W-1:0] sval_hw;
	logic [almsc_pkg::POS_W-1:0] tval_hw;
	logic [31:0]                 rdata;
	logic [almsc_pkg::IRQ_W-1:0] ev;
	logic [almsc_pkg::IRQ_W-1:0] w1c;

	// ==========================================================
	// pin synchronisers and lock unit
	almsc_sync #(
		.W (2)
	) u_sync (
		.clock (clock),
		.rst_n (rst_n),
		.ce    (ce),
		.din   ({trigger_pin, state_pin}),
		.dout  (pins_s)
	);

	assign trg_s = pins_s[1];
	assign sta_s = pins_s[0];

	almsc_lock_if lk ();

	almsc_lock u_lock (
		.clock (clock),
		.rst_n (rst_n),
		.ce    (ce),
		.lk    (lk.lock_unit)
	);

	assign lk.enable      = q.en;
	assign lk.emergency   = q.mode[almsc_pkg::MODE_EMERG_BIT];
	assign lk.dir_change  = q.en && (direction_fwd != q.dir_d);
	assign lk.gap         = q.en && missing_state_event;
	assign lk.state_slope = sta_slope;
	assign lock_now       = lk.lock;

	// ==========================================================
	// slopes and corrected values
	always_comb begin
		trg_slope = q.en && q.mode[almsc_pkg::MODE_TEN_BIT] && trg_s && !q.trg_d;
		sta_slope = q.en && q.mode[almsc_pkg::MODE_SEN_BIT] && sta_s && !q.sta_d;
		corr_s    = increment_counter_primary - state_pulse_count;
		corr_t    = increment_counter_primary - trigger_pulse_count;
		if (q.nocorr) begin
			sval_hw = state_side_position_measured;
			tval_hw = trigger_side_position_measured;
		end else if (direction_fwd) begin
			sval_hw = state_side_position_measured + corr_s;
			tval_hw = trigger_side_position_measured + corr_t;
		end else begin
			sval_hw = state_side_position_measured - corr_s;
			tval_hw = trigger_side_position_measured - corr_t;
		end
	end

	// ==========================================================
	// apb decode and read mux
	assign acc       = psel && penable && q.pready;
	assign wr        = acc && pwrite;
	assign new_emerg = pwdata[almsc_pkg::MODE_EMERG_BIT];

	always_comb begin
		hit   = 1'b1;
		rdata = 32'h00000000;
		unique case (paddr)
			almsc_pkg::OFF_MODE: begin
				rdata[almsc_pkg::MODE_W-1:0] = q.mode;
			end
			almsc_pkg::OFF_ENABLE: begin
				rdata[almsc_pkg::ENABLE_BIT] = q.en;
			end
			almsc_pkg::OFF_SVAL: begin
				rdata[almsc_pkg::POS_W-1:0] = q.sval;
			end
			almsc_pkg::OFF_TVAL: begin
				rdata[almsc_pkg::POS_W-1:0] = q.tval;
			end
			almsc_pkg::OFF_STATUS: begin
				rdata[almsc_pkg::STAT_LOCK_BIT]   = lock_now;
				rdata[almsc_pkg::STAT_PEND_S_BIT] = q.pend_s;
				rdata[almsc_pkg::STAT_PEND_T_BIT] = q.pend_t;
				rdata[almsc_pkg::STAT_NOCORR_BIT] = q.nocorr;
			end
			almsc_pkg::OFF_ISTAT: begin
				rdata[almsc_pkg::IRQ_W-1:0] = q.ist;
			end
			almsc_pkg::OFF_IMASK: begin
				rdata[almsc_pkg::IRQ_W-1:0] = q.imask;
			end
			default: begin
				hit = 1'b0;
			end
		endcase
	end

	// ==========================================================
	// next state
	always_comb begin
		d       = q;
		ev      = '0;
		w1c     = '0;
		d.trg_d = trg_s;
		d.sta_d = sta_s;
		d.dir_d = direction_fwd;
		d.lock_d = lock_now;

		// one wait state: setup, then two access cycles
		d.pready  = psel && penable && !q.pready;
		d.pslverr = psel && penable && !q.pready && !hit;
		if (psel && penable && !q.pready) begin
			d.prdata = pwrite ? 32'h00000000 : rdata;
		end

		// cpu writes land first so a slope update in the same cycle wins
		if (wr && hit) begin
			unique case (paddr)
				almsc_pkg::OFF_MODE: begin
					d.mode = pwdata[almsc_pkg::MODE_W-1:0];
					if (q.en && new_emerg && !q.mode[almsc_pkg::MODE_EMERG_BIT]) begin
						d.pend_s = 1'b1;
						d.pend_t = 1'b0;
						d.nocorr = 1'b0;
					end else if (q.en && !new_emerg
						&& q.mode[almsc_pkg::MODE_EMERG_BIT]) begin
						d.pend_t = 1'b1;
						d.pend_s = 1'b0;
						d.nocorr = 1'b0;
					end
				end
				almsc_pkg::OFF_ENABLE: begin
					d.en = pwdata[almsc_pkg::ENABLE_BIT];
					if (!pwdata[almsc_pkg::ENABLE_BIT]) begin
						// disabling drops any half-done switch
						d.pend_s = 1'b0;
						d.pend_t = 1'b0;
						d.nocorr = 1'b0;
					end else if (!q.en) begin
						// relies on mode being set before enable
						d.nocorr = 1'b1;
						d.pend_s = q.mode[almsc_pkg::MODE_EMERG_BIT];
						d.pend_t = !q.mode[almsc_pkg::MODE_EMERG_BIT];
					end
				end
				almsc_pkg::OFF_SVAL: begin
					d.sval = pwdata[almsc_pkg::POS_W-1:0];
				end
				almsc_pkg::OFF_TVAL: begin
					d.tval = pwdata[almsc_pkg::POS_W-1:0];
				end
				almsc_pkg::OFF_ISTAT: begin
					w1c = pwdata[almsc_pkg::IRQ_W-1:0];
				end
				almsc_pkg::OFF_IMASK: begin
					d.imask = pwdata[almsc_pkg::IRQ_W-1:0];
				end
				default: begin
				end
			endcase
		end

		// values stay put until their qualifying slope
		if (q.pend_s && sta_slope) begin
			d.sval   = sval_hw;
			d.pend_s = 1'b0;
			d.nocorr = 1'b0;
			ev[almsc_pkg::IRQ_SVAL_BIT] = 1'b1;
		end
		if (q.pend_t && trg_slope) begin
			d.tval   = tval_hw;
			d.pend_t = 1'b0;
			d.nocorr = 1'b0;
			ev[almsc_pkg::IRQ_TVAL_BIT] = 1'b1;
		end

		ev[almsc_pkg::IRQ_LOST_BIT]   = q.lock_d && !lock_now;
		ev[almsc_pkg::IRQ_REGAIN_BIT] = !q.lock_d && lock_now;

		// a new event wins over a clear in the same cycle
		d.ist = (q.ist & ~w1c) | ev;
		d.irq = |(d.ist & d.imask);
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			q       <= '0;
			q.mode  <= almsc_pkg::MODE_RST;
			q.sval  <= almsc_pkg::POS_RST;
			q.tval  <= almsc_pkg::POS_RST;
			q.ist   <= almsc_pkg::IRQ_RST;
			q.imask <= almsc_pkg::IRQ_RST;
		end else if (ce) begin
			q <= d;
		end
	end

	// ==========================================================
	// outputs, all from flops
	assign prdata                      = q.prdata;
	assign pready                      = q.pready;
	assign pslverr                     = q.pslverr;
	assign irq                         = q.irq;
	assign state_side_position_value   = q.sval;
	assign trigger_side_position_value = q.tval;
	assign emergency_mode_select       = q.mode[almsc_pkg::MODE_EMERG_BIT];
	assign loop_enable_bit             = q.en;
	assign primary_phase_locked_flag   = lock_now;
endmodule : almsc_top

// *** tb/almsc_props.sv ***
// Purpose: port checks of the angle loop mode-switch block
// Assumes: one clock, synchronous active-low reset
// Notes:   bound to almsc_top
`timescale 1ns/1ps
module almsc_props (
	input wire logic                         clock,
	input wire logic                         rst_n,
	input wire logic [almsc_pkg::ADDR_W-1:0] paddr,
	input wire logic                         penable,
	input wire logic                         pwrite,
	input wire logic [31:0]                  pwdata,
	input wire logic                         pready,
	input wire logic                         pslverr,
	input wire logic                         trigger_pin,
	input wire logic                         state_pin,
	input wire logic                         direction_fwd,
	input wire logic                         missing_state_event,
	input wire logic [almsc_pkg::POS_W-1:0]  state_side_position_value,
	input wire logic [almsc_pkg::POS_W-1:0]  trigger_side_position_value,
	input wire logic                         emergency_mode_select,
	input wire logic                         loop_enable_bit,
	input wire logic                         primary_phase_locked_flag
);
	// ==========================================================
	// properties
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	chk_one_wait: assert property ($rose(penable) |-> !pready ##1 pready)
		else $error("apb answer not after one wait state");
	chk_ready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	chk_unmapped_err: assert property (pready |-> pslverr == (paddr > almsc_pkg::OFF_IMASK
		|| paddr[1:0] != 2'h0))
		else $error("pslverr does not match the address");
	chk_mode_write: assert property (pready && pwrite && paddr == almsc_pkg::OFF_MODE
		|=> 32'(emergency_mode_select) == ($past(pwdata) & 32'h1))
		else $error("emergency select not taken from write");
	chk_enable_write: assert property (pready && pwrite && paddr == almsc_pkg::OFF_ENABLE
		|=> 32'(loop_enable_bit) == ($past(pwdata) & 32'h1))
		else $error("loop enable not taken from write");
	chk_dir_clear: assert property (
		$changed(direction_fwd) && emergency_mode_select && loop_enable_bit
		|-> ##[1:3] !primary_phase_locked_flag)
		else $error("lock kept over a direction change");
	chk_regain_gap: assert property (
		$rose(primary_phase_locked_flag) |-> $past(missing_state_event))
		else $error("lock regained without a gap");
	chk_sval_cause: assert property (
		$changed(state_side_position_value) |-> $past(pready) || $past(state_pin)
		|| $past(state_pin, 2) || $past(state_pin, 3))
		else $error("state value moved without slope or write");
	chk_tval_cause: assert property (
		$changed(trigger_side_position_value) |-> $past(pready) || $past(trigger_pin)
		|| $past(trigger_pin, 2) || $past(trigger_pin, 3))
		else $error("trigger value moved without slope or write");

	cover property ($rose(primary_phase_locked_flag));
	cover property ($fell(primary_phase_locked_flag));
	cover property (pready && pslverr);
endmodule : almsc_props

bind almsc_top almsc_props u_props (.clock, .rst_n, .paddr, .penable, .pwrite, .pwdata,
	.pready, .pslverr, .trigger_pin, .state_pin, .direction_fwd, .missing_state_event,
	.state_side_position_value, .trigger_side_position_value, .emergency_mode_select,
	.loop_enable_bit, .primary_phase_locked_flag);

// *** tb/almsc_sensor_model.sv ***
// Purpose: sensor pins and loop core values seen by the block
// Assumes: values are steady between slopes
// Notes:   pins idle low outside a slope
`timescale 1ns/1ps
module almsc_sensor_model #(
	parameter logic [23:0] MS = 24'h001000,
	parameter logic [23:0] MT = 24'h002000,
	parameter logic [23:0] INC = 24'h000050,
	parameter logic [23:0] PS = 24'h000010,
	parameter logic [23:0] PT = 24'h000020
) (
	input  wire logic        clock,
	output logic             trigger_pin,
	output logic             state_pin,
	output logic [23:0]      state_side_position_measured,
	output logic [23:0]      trigger_side_position_measured,
	output logic [23:0]      increment_counter_primary,
	output logic [23:0]      state_pulse_count,
	output logic [23:0]      trigger_pulse_count
);
	// ==========================================================
	// stimulus
	assign state_side_position_measured   = MS;
	assign trigger_side_position_measured = MT;
	assign increment_counter_primary      = INC;
	assign state_pulse_count              = PS;
	assign trigger_pulse_count            = PT;
	initial begin
		trigger_pin = 1'b0;
		state_pin   = 1'b0;
	end
	// held four edges so the two-flop synchroniser cannot miss it
	task automatic pulse(input bit s);
		@(posedge clock);
		if (s) state_pin <= 1'b1;
		else trigger_pin <= 1'b1;
		repeat (4) @(posedge clock);
		state_pin   <= 1'b0;
		trigger_pin <= 1'b0;
		repeat (6) @(posedge clock);
	endtask : pulse
endmodule : almsc_sensor_model

// *** tb/almsc_top_tb.sv ***
// Purpose: self-checking bench of the mode-switch correction block
// Assumes: apb master, one transfer at a time
// Notes:   sensor side comes from almsc_sensor_model
`timescale 1ns/1ps
module almsc_top_tb;
	localparam logic [23:0] MS = 24'h001000;
	localparam logic [23:0] MT = 24'h002000;
	localparam logic [23:0] INC = 24'h000050;
	localparam logic [23:0] PS = 24'h000010;
	localparam logic [23:0] PT = 24'h000020;
	logic        clock = 1'b0;
	logic        rst_n = 1'b0;
	logic        ce = 1'b1;
	logic [7:0]  paddr = 8'h00;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0;
	logic        direction_fwd = 1'b1;
	logic        missing_state_event = 1'b0;
	logic [31:0] prdata;
	logic        pready, pslverr, irq, trigger_pin, state_pin;
	logic        emergency_mode_select, loop_enable_bit, primary_phase_locked_flag;
	logic [23:0] state_side_position_measured, trigger_side_position_measured;
	logic [23:0] increment_counter_primary, state_pulse_count, trigger_pulse_count;
	logic [23:0] state_side_position_value, trigger_side_position_value;
	int          failures = 0;
	int          cmp_count = 0;

	always #20 clock = ~clock;

	almsc_top u_dut (.*);
	almsc_sensor_model #(.MS(MS), .MT(MT), .INC(INC), .PS(PS), .PT(PT)) u_far (.*);

	// ==========================================================
	// tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		@(posedge clock);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clock);
		penable <= 1'b1;
		// answer and read data are taken at the completing rising edge; a hang is the watchdog's
		do begin
			@(posedge clock);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
		logic [31:0] r;
		logic        e;
		apb(1'b0, a, 32'h0, r, e);
		chk(r, x);
		chk({31'h0, e}, {31'h0, xe});
	endtask : rd
	// w selects irq, else the lock flag
	task automatic flag(input bit w, input logic x);
		@(negedge clock);
		chk({31'h0, w ? irq : primary_phase_locked_flag}, {31'h0, x});
	endtask : flag
	task automatic gap;
		@(posedge clock);
		missing_state_event <= 1'b1;
		@(posedge clock);
		missing_state_event <= 1'b0;
		repeat (2) @(posedge clock);
	endtask : gap
	task automatic complete_run;
		$display("compares %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : complete_run

	// ==========================================================
	// tests
	initial begin
		repeat (4) @(posedge clock);
		rst_n <= 1'b1;
		for (int i = 0; i < 7; i++) rd(8'(4 * i), 32'h0, 1'b0);
		rd(8'h1C, 32'h0, 1'b1);
		wr(almsc_pkg::OFF_MODE, 32'h6);
		wr(almsc_pkg::OFF_IMASK, 32'h1);
		wr(almsc_pkg::OFF_ENABLE, 32'h1);
		u_far.pulse(1'b0);
		rd(almsc_pkg::OFF_TVAL, {8'h0, MT}, 1'b0);
		rd(almsc_pkg::OFF_ISTAT, 32'h2, 1'b0);
		flag(1'b1, 1'b0);
		wr(almsc_pkg::OFF_IMASK, 32'hF);
		flag(1'b1, 1'b1);
		wr(almsc_pkg::OFF_ISTAT, 32'hF);
		flag(1'b1, 1'b0);
		wr(almsc_pkg::OFF_MODE, 32'h7);
		rd(almsc_pkg::OFF_STATUS, 32'h2, 1'b0);
		u_far.pulse(1'b0);
		rd(almsc_pkg::OFF_TVAL, {8'h0, MT}, 1'b0);
		rd(almsc_pkg::OFF_SVAL, 32'h0, 1'b0);
		u_far.pulse(1'b1);
		rd(almsc_pkg::OFF_SVAL, {8'h0, MS + INC - PS}, 1'b0);
		for (int k = 0; k < 2; k++) begin
			flag(1'b0, 1'b0);
			gap();
			flag(1'b0, 1'b0);
			gap();
			flag(1'b0, 1'b1);
			@(posedge clock);
			direction_fwd <= ~direction_fwd;
			repeat (3) @(posedge clock);
		end
		// backward direction for the switch back to normal mode
		@(posedge clock);
		direction_fwd <= 1'b0;
		wr(almsc_pkg::OFF_MODE, 32'h6);
		u_far.pulse(1'b0);
		rd(almsc_pkg::OFF_TVAL, {8'h0, MT - (INC - PT)}, 1'b0);
		chk({8'h0, trigger_side_position_value}, {8'h0, MT - (INC - PT)});
		wr(almsc_pkg::OFF_SVAL, 32'h00ABCD);
		rd(almsc_pkg::OFF_SVAL, 32'h00ABCD, 1'b0);
		wr(almsc_pkg::OFF_ENABLE, 32'h0);
		wr(almsc_pkg::OFF_MODE, 32'h7);
		wr(almsc_pkg::OFF_ENABLE, 32'h1);
		u_far.pulse(1'b1);
		rd(almsc_pkg::OFF_SVAL, {8'h0, MS}, 1'b0);
		// frozen clock enable: two gaps must not regain lock
		@(posedge clock);
		ce <= 1'b0;
		gap();
		gap();
		flag(1'b0, 1'b0);
		@(posedge clock);
		ce <= 1'b1;
		@(negedge clock);
		chk({8'h0, state_side_position_value}, {8'h0, MS});
		chk({30'h0, emergency_mode_select, loop_enable_bit}, 32'h00000003);
		complete_run();
	end

	// a hang counts as a mismatch
	initial begin
		repeat (5000) @(posedge clock);
		failures++;
		complete_run();
	end
endmodule : almsc_top_tb
